/* rtl/rcf_pkg.sv */
// Constants shared by the reset cause flag block
package rcf_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_FLAGS    = 8'h00;
  localparam logic [7:0] OFF_CONFIG   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;

  // ==========================================================================
  // Flag and config field positions
  localparam int BIT_STK_OVF  = 7;
  localparam int BIT_STK_UNF  = 6;
  localparam int BIT_WDT_N    = 4;
  localparam int BIT_PIN_N    = 3;
  localparam int BIT_INSTR_N  = 2;
  localparam int BIT_POR_N    = 1;
  localparam int BIT_BOR_N    = 0;
  localparam int BIT_CFG_STK_EN = 0;

  // ==========================================================================
  // Reset and load values
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'hdf;
  localparam logic [7:0] FLAGS_POR_VAL   = 8'h1c;
  localparam logic [7:0] FLAGS_BOR_VAL   = 8'h1c;
  localparam logic [7:0] FLAGS_BOR_KEEP  = 8'h02;
  localparam logic [7:0] IRQ_STAT_RST    = 8'h02;
  localparam logic [7:0] IRQ_MASK_RST    = 8'h00;
  localparam logic       CFG_STK_EN_RST  = 1'b0;

endpackage : rcf_pkg

/* rtl/rcf_reg_if.sv */
// Register access carrier between the bus slave and the flag core
`timescale 1ns/100ps
`default_nettype none

interface rcf_reg_if;
  logic [7:0]  addr;
  logic        wr_stb;
  logic [7:0]  wdata;
  logic [31:0] rdata;

  modport slave
  (
    output addr,
    output wr_stb,
    output wdata,
    input  rdata
  );

  modport core
  (
    input  addr,
    input  wr_stb,
    input  wdata,
    output rdata
  );
endinterface : rcf_reg_if

`default_nettype wire

/* rtl/rcf_sync.sv */
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none

module rcf_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rcf_sync_st_t;

  rcf_sync_st_t st_q;
  rcf_sync_st_t st_d;

  always_comb
  begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule : rcf_sync

`default_nettype wire

/* rtl/rcf_wb_slave.sv */
// Classic Wishbone slave front end for the reset cause flag block
`timescale 1ns/100ps
`default_nettype none

module rcf_wb_slave (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  rcf_reg_if.slave         regs
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rcf_wb_st_t;

  rcf_wb_st_t st_q;
  rcf_wb_st_t st_d;
  logic       req;

  // ==========================================================================
  // One wait state: ack in the cycle after the request, dropped the next
  always_comb
  begin
    req      = wb_cyc_i && wb_stb_i;
    st_d     = st_q;
    st_d.ack = req && !st_q.ack;
    if (req && !st_q.ack && !wb_we_i)
    begin
      st_d.dat = regs.rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Write takes effect at the edge where the master sees ack
  assign regs.addr   = wb_adr_i;
  assign regs.wdata  = wb_dat_i[7:0];
  assign regs.wr_stb = req && wb_we_i && st_q.ack && wb_sel_i[0];
  assign wb_ack_o    = st_q.ack;
  assign wb_dat_o    = st_q.dat;

endmodule : rcf_wb_slave

`default_nettype wire

/* rtl/rcf_top.sv */
// Reset cause flag register with Wishbone access and event interrupt
//
// How it works
// - Apart from power-on and brown-out, a reset cause changes only its own flag, all other flags hold their value.
// - Once running, only software and a brown-out move a flag back to its inactive level.
// - Software may write any flag to its active level, it reads back and triggers no reset.
// - Bit 7 is set on stack overflow, is zero after power-on or brown-out, software may clear it.
// - Bit 6 is set on stack underflow, is zero after power-on or brown-out, software may clear it.
// - Bit 4 goes low on a watchdog reset, is one after power-on or brown-out, firmware may set it.
// - Bit 3 goes low on an external pin reset and firmware may set it back to one.
// - Bit 2 goes low on a reset instruction, is one after power-on or brown-out, firmware may set it.
// - Bit 1 goes low on power-on and software must set it to see the next power-on.
// - Bit 0 goes low on brown-out and software must set it after power-on or brown-out.
// - Stack overflow or underflow resets and is recorded only while the stack reset enable is one.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rcf_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        external_reset_pin_n,
  input  wire logic        brownout_detect,
  input  wire logic        watchdog_timeout,
  input  wire logic        reset_instr_exec,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  output logic      [7:0]  reset_cause_flags,
  output logic             stack_reset_req,
  output logic             irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] flags;
    logic       stk_en;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic       stk_req;
    logic       pin_prev_n;
    logic       bor_prev;
  } rcf_st_t;

  rcf_st_t     st_q;
  rcf_st_t     st_d;
  logic        pin_n_s;
  logic        bor_s;
  logic        pin_fall;
  logic        bor_rise;
  logic        stk_ovf_ev;
  logic        stk_unf_ev;
  logic [7:0]  events;
  logic [31:0] rdata;

  rcf_reg_if   regs ();

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  // ==========================================================================
  // Bus front end and pin synchronisers
  rcf_wb_slave u_wb
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .regs     (regs.slave)
  );

  rcf_sync #(
    .W       (2),
    .RST_VAL (2'h1)
  ) u_sync
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({brownout_detect, external_reset_pin_n}),
    .sync_out ({bor_s, pin_n_s})
  );

  // ==========================================================================
  // Cause events
  always_comb
  begin
    pin_fall   = st_q.pin_prev_n && !pin_n_s;
    bor_rise   = bor_s && !st_q.bor_prev;
    stk_ovf_ev = stack_overflow && st_q.stk_en;
    stk_unf_ev = stack_underflow && st_q.stk_en;
    events                = '0;
    events[rcf_pkg::BIT_STK_OVF] = stk_ovf_ev;
    events[rcf_pkg::BIT_STK_UNF] = stk_unf_ev;
    events[rcf_pkg::BIT_WDT_N]   = watchdog_timeout;
    events[rcf_pkg::BIT_PIN_N]   = pin_fall;
    events[rcf_pkg::BIT_INSTR_N] = reset_instr_exec;
    events[rcf_pkg::BIT_BOR_N]   = bor_rise;
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_d            = st_q;
    st_d.pin_prev_n = pin_n_s;
    st_d.bor_prev   = bor_s;
    st_d.stk_req    = stk_ovf_ev || stk_unf_ev;

    // Software first, so a cause in the same cycle wins over the write
    if (regs.wr_stb)
    begin
      if (reg_hit(regs.addr, rcf_pkg::OFF_FLAGS))
      begin
        st_d.flags = regs.wdata & rcf_pkg::FLAGS_IMPL_MASK;
      end
      if (reg_hit(regs.addr, rcf_pkg::OFF_CONFIG))
      begin
        st_d.stk_en = regs.wdata[rcf_pkg::BIT_CFG_STK_EN];
      end
      if (reg_hit(regs.addr, rcf_pkg::OFF_IRQ_STAT))
      begin
        st_d.irq_stat = st_q.irq_stat & ~regs.wdata;
      end
      if (reg_hit(regs.addr, rcf_pkg::OFF_IRQ_MASK))
      begin
        st_d.irq_mask = regs.wdata & rcf_pkg::FLAGS_IMPL_MASK;
      end
    end

    // Brown-out loads defaults except the power-on bit
    if (bor_rise)
    begin
      st_d.flags = (st_d.flags & rcf_pkg::FLAGS_BOR_KEEP)
                 | rcf_pkg::FLAGS_BOR_VAL;
    end

    // Each cause touches its own bit only, and only toward active
    if (watchdog_timeout)
    begin
      st_d.flags[rcf_pkg::BIT_WDT_N] = 1'b0;
    end
    if (!pin_n_s)
    begin
      st_d.flags[rcf_pkg::BIT_PIN_N] = 1'b0;
    end
    if (reset_instr_exec)
    begin
      st_d.flags[rcf_pkg::BIT_INSTR_N] = 1'b0;
    end
    if (stk_ovf_ev)
    begin
      st_d.flags[rcf_pkg::BIT_STK_OVF] = 1'b1;
    end
    if (stk_unf_ev)
    begin
      st_d.flags[rcf_pkg::BIT_STK_UNF] = 1'b1;
    end

    st_d.irq_stat = (st_d.irq_stat | events) & rcf_pkg::FLAGS_IMPL_MASK;
  end

  // ==========================================================================
  // Registers; only the power-on reset initialises the flags
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q.flags      <= rcf_pkg::FLAGS_POR_VAL;
      st_q.stk_en     <= rcf_pkg::CFG_STK_EN_RST;
      st_q.irq_stat   <= rcf_pkg::IRQ_STAT_RST;
      st_q.irq_mask   <= rcf_pkg::IRQ_MASK_RST;
      st_q.stk_req    <= 1'b0;
      st_q.pin_prev_n <= 1'b1;
      st_q.bor_prev   <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Read mux, unmapped addresses read zero
  always_comb
  begin
    rdata = '0;
    if (reg_hit(regs.addr, rcf_pkg::OFF_FLAGS))
    begin
      rdata[7:0] = st_q.flags & rcf_pkg::FLAGS_IMPL_MASK;
    end
    else if (reg_hit(regs.addr, rcf_pkg::OFF_CONFIG))
    begin
      rdata[rcf_pkg::BIT_CFG_STK_EN] = st_q.stk_en;
    end
    else if (reg_hit(regs.addr, rcf_pkg::OFF_IRQ_STAT))
    begin
      rdata[7:0] = st_q.irq_stat;
    end
    else if (reg_hit(regs.addr, rcf_pkg::OFF_IRQ_MASK))
    begin
      rdata[7:0] = st_q.irq_mask;
    end
  end

  assign regs.rdata        = rdata;
  assign reset_cause_flags = st_q.flags;
  assign stack_reset_req   = st_q.stk_req;
  assign irq               = |(st_q.irq_stat & st_q.irq_mask);

endmodule : rcf_top

`default_nettype wire

/* test/rcf_top_monitor.sv */
// Assertion checker for the reset cause flag block
`timescale 1ns/100ps
`default_nettype none

module rcf_top_monitor (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       external_reset_pin_n,
  input wire logic       brownout_detect,
  input wire logic       watchdog_timeout,
  input wire logic       reset_instr_exec,
  input wire logic [7:0] reset_cause_flags,
  input wire logic       stack_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Recent brown-out history
  logic [5:0] bor_hist_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bor_hist_q <= 6'h00;
    else
      bor_hist_q <= {bor_hist_q[4:0], brownout_detect};
  end

  // ==========================================================================
  // Properties
  sequence s_bor_on;
    $rose(brownout_detect) ##1 brownout_detect [*3];
  endsequence
  sequence s_bor_val;
    reset_cause_flags[7:6] == 2'b00 && reset_cause_flags[4:2] == 3'b111 && !reset_cause_flags[0];
  endsequence
  property p_bor_load;
    s_bor_on |-> ##[1:4] s_bor_val;
  endproperty
  property p_bit5;
    reset_cause_flags[5] == 1'b0;
  endproperty
  property p_wdt;
    watchdog_timeout |=> !reset_cause_flags[4];
  endproperty
  property p_instr;
    reset_instr_exec |=> !reset_cause_flags[2];
  endproperty
  property p_stack;
    stack_reset_req |-> reset_cause_flags[7] || reset_cause_flags[6];
  endproperty
  property p_no_hw_clear;
    $rose(reset_cause_flags[4]) |-> $past(wb_ack_o && wb_we_i) || (|bor_hist_q);
  endproperty
  property p_pin;
    !external_reset_pin_n [*4] |-> !reset_cause_flags[3];
  endproperty
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty

  a_bor_load: assert property (p_bor_load)
    else $error("brown-out load value wrong");
  a_bit5: assert property (p_bit5)
    else $error("unused flag bit set");
  a_wdt: assert property (p_wdt)
    else $error("watchdog flag not cleared");
  a_instr: assert property (p_instr)
    else $error("instruction flag not cleared");
  a_stack: assert property (p_stack)
    else $error("stack request without flag");
  a_no_hw_clear: assert property (p_no_hw_clear)
    else $error("watchdog flag rose without write");
  a_pin: assert property (p_pin)
    else $error("pin flag not held low");
  a_ack_resp: assert property (p_ack_resp)
    else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
endmodule : rcf_top_monitor

`default_nettype wire

/* test/tb_rcf_top.sv */
// Self-checking testbench for the reset cause flag block
`timescale 1ns/100ps
`default_nettype none

module tb_rcf_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic        pin_n = 1'b1;
  logic        bor = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic [7:0]  flags;
  logic        req;
  logic        irq;
  logic [7:0]  d;
  int          seed = 70;
  int          nreq = 0;
  int          num_errors = 0;
  int          num_checks = 0;

  rcf_top dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .external_reset_pin_n(pin_n), .brownout_detect(bor), .watchdog_timeout(ev[0]),
    .reset_instr_exec(ev[1]), .stack_overflow(ev[2]), .stack_underflow(ev[3]),
    .reset_cause_flags(flags), .stack_reset_req(req), .irq(irq));

  initial
  begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (req === 1'b1)
      nreq++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask : chk

  // Flag value expected after one cause pulse on ev[k]
  function automatic logic [7:0] exp_cause(input logic [7:0] f, input int k);
    logic [7:0] e;
    e = f;
    case (k)
      0:       e[rcf_pkg::BIT_WDT_N]   = 1'b0;
      1:       e[rcf_pkg::BIT_INSTR_N] = 1'b0;
      2:       e[rcf_pkg::BIT_STK_OVF] = 1'b1;
      default: e[rcf_pkg::BIT_STK_UNF] = 1'b1;
    endcase
    return e;
  endfunction : exp_cause

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v,
                     input logic [3:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h0, v};
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        $display("Error ack expected 1 seen 0");
        num_errors++;
        complete_run();
      end
      @(posedge clk);
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    bus(1'b1, a, v, 4'hf, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(rcf_pkg::OFF_FLAGS, 8'h1c);
    rd(rcf_pkg::OFF_IRQ_STAT, 8'h02);
    rd(rcf_pkg::OFF_CONFIG, 8'h00);
    rd(rcf_pkg::OFF_IRQ_MASK, 8'h00);
    wr(rcf_pkg::OFF_FLAGS, 8'hff);
    rd(rcf_pkg::OFF_FLAGS, 8'hdf);
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($random(seed));
      wr(rcf_pkg::OFF_FLAGS, d);
      rd(rcf_pkg::OFF_FLAGS, d & rcf_pkg::FLAGS_IMPL_MASK);
    end
    for (int i = 0; i < 6; i++)
    begin
      d = 8'({$random(seed)} % 2);
      wr(rcf_pkg::OFF_FLAGS, 8'h1f);
      pulse(int'(d));
      rd(rcf_pkg::OFF_FLAGS, exp_cause(8'h1f, int'(d)));
    end
    wr(rcf_pkg::OFF_FLAGS, 8'h0f);
    pulse(2);
    pulse(3);
    rd(rcf_pkg::OFF_FLAGS, 8'h0f);
    wr(rcf_pkg::OFF_CONFIG, 8'h01);
    pulse(2);
    rd(rcf_pkg::OFF_FLAGS, exp_cause(8'h0f, 2));
    pulse(3);
    rd(rcf_pkg::OFF_FLAGS, exp_cause(8'h8f, 3));
    chk("stack requests", 8'h02, 8'(nreq));
    wr(rcf_pkg::OFF_FLAGS, 8'h1f);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(rcf_pkg::OFF_FLAGS, 8'h17);
    wr(rcf_pkg::OFF_IRQ_STAT, 8'hff);
    rd(rcf_pkg::OFF_IRQ_STAT, 8'h00);
    wr(rcf_pkg::OFF_IRQ_MASK, 8'h04);
    pulse(0);
    chk("irq masked", 8'h00, {7'h0, irq});
    pulse(1);
    chk("irq", 8'h01, {7'h0, irq});
    rd(rcf_pkg::OFF_IRQ_STAT, 8'h14);
    wr(rcf_pkg::OFF_IRQ_STAT, 8'h04);
    @(posedge clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(rcf_pkg::OFF_FLAGS, 8'hc3);
    bus(1'b1, rcf_pkg::OFF_FLAGS, 8'h1f, 4'he, d);
    rd(rcf_pkg::OFF_FLAGS, 8'hc3);
    bor <= 1'b1;
    repeat (8) @(posedge clk);
    bor <= 1'b0;
    repeat (4) @(posedge clk);
    rd(rcf_pkg::OFF_FLAGS, 8'h1e);
    repeat (10) @(posedge clk);
    rd(rcf_pkg::OFF_FLAGS, 8'h1e);
    chk("flags port", 8'h1e, flags);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(rcf_pkg::OFF_FLAGS, rcf_pkg::FLAGS_POR_VAL);
    chk("flags port", rcf_pkg::FLAGS_POR_VAL, flags);
    rd(rcf_pkg::OFF_IRQ_STAT, rcf_pkg::IRQ_STAT_RST);
    complete_run();
  end
endmodule : tb_rcf_top

bind rcf_top rcf_top_monitor u_mon (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .external_reset_pin_n, .brownout_detect, .watchdog_timeout, .reset_instr_exec,
  .reset_cause_flags, .stack_reset_req);

`default_nettype wire
